// File: mvx_params.svh
// constants of the mac video expansion path
`ifndef MVX_PARAMS_SVH
`define MVX_PARAMS_SVH
`define MVX_IDX_SAT 8'd23
`define MVX_IDX_CONTRAST 8'd200
`define MVX_IDX_MODE 8'd201
`define MVX_IDX_STATUS 8'd208
`define MVX_CONTRAST_LSB 10
`define MVX_BUS8_BIT 6
`define MVX_LUMA_SEL_LSB 10
`define MVX_CHROMA_SEL_LSB 13
`define MVX_SAT_U_LSB 0
`define MVX_SAT_V_LSB 6
`define MVX_CONTRAST_RST 6'h20
`define MVX_SAT_RST 6'h20
`define MVX_GAIN_SHIFT 5
`define MVX_TICKS_PER_CHROMA 2'd3
`define MVX_CHROMA_CYCLE 3'd6
`define MVX_LUMA_AW 10
`define MVX_CHROMA_AW 9
`endif

// File: mvx_pkg.sv
// types of the mac video expansion path
`default_nettype none
package mvx_pkg;
    typedef struct packed {
        logic [5:0] contrast;
        logic [1:0] luma_filter_select;
        logic [2:0] chroma_filter_select;
        logic bus8;
        logic [5:0] sat_u;
        logic [5:0] sat_v;
    } mvx_ctrl_t;
    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic chroma_valid;
    } mvx_video_t;
    typedef enum logic [3:0] {
        MVX_U_HI = 4'h1,
        MVX_U_LO = 4'h2,
        MVX_V_HI = 4'h4,
        MVX_V_LO = 4'h8
    } mvx_slot_t;
endpackage
`default_nettype wire

// File: mvx_line_ram.sv
// single-port-write, registered-read line memory
`default_nettype none
module mvx_line_ram #(
    parameter int AW = 10
) (
    // clock
    input wire logic clk_i,
    input wire logic ce_i,
    // write side
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read side
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// File: mvx_sat_mul.sv
// gain multiplier with clamping, gain is factor/32
`default_nettype none
`include "mvx_params.svh"
module mvx_sat_mul #(
    parameter bit SIGNED = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // operands
    input wire logic [7:0] a_i,
    input wire logic [5:0] k_i,
    // result
    output logic [7:0] p_o
);
    logic signed [15:0] prod;
    logic signed [15:0] scaled;
    always_comb begin
        if (SIGNED) begin
            prod = 16'(signed'(a_i)) * 16'(signed'({1'b0, k_i}));
        end else begin
            prod = 16'({8'h00, a_i}) * 16'({10'h000, k_i});
        end
        scaled = prod >>> `MVX_GAIN_SHIFT;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p_o <= 8'h00;
        end else if (ce_i) begin
            if (!SIGNED && scaled > 16'sh00ff) begin
                p_o <= 8'hff;
            end else if (SIGNED && scaled > 16'sh007f) begin
                p_o <= 8'h7f;
            end else if (SIGNED && scaled < -16'sh0080) begin
                p_o <= 8'h80;
            end else begin
                p_o <= scaled[7:0];
            end
        end
    end
    property p_clamp;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !SIGNED && scaled > 16'sh00ff) |=> (p_o == 8'hff);
    endproperty
    a_clamp: assert property (p_clamp) else $error("gain product did not clamp");
endmodule
`default_nettype wire

// File: mvx_video_path.sv
// mac video expansion path with wishbone control registers
//
// The Wishbone slave port and the placing of the registers were decided locally.
`default_nettype none
`include "mvx_params.svh"
module mvx_video_path (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // baseband samples, one per enabled cycle
    input wire logic [7:0] sample_i,
    input wire logic line_start_i,
    input wire logic frame_start_i,
    input wire logic luma_wr_i,
    input wire logic chroma_wr_i,
    // codec side
    output mvx_pkg::mvx_video_t video_o,
    output logic chroma_bus8_o
);
    import mvx_pkg::*;

    mvx_ctrl_t ctrl_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic req;
    logic [9:0] idx;
    logic parity_q;
    logic [9:0] line_cnt_q;

    // register bus
    assign req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[11:2];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req && !ack_q;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (ce_i && req && !ack_q) begin
            case (idx)
                10'(`MVX_IDX_CONTRAST):
                    rdat_q <= {16'h0000, ctrl_q.contrast, 10'h000};
                10'(`MVX_IDX_MODE):
                    rdat_q <= {16'h0000, ctrl_q.chroma_filter_select, 1'b0, ctrl_q.luma_filter_select,
                        3'h0, ctrl_q.bus8, 6'h00};
                10'(`MVX_IDX_SAT):
                    rdat_q <= {20'h00000, ctrl_q.sat_v, ctrl_q.sat_u};
                10'(`MVX_IDX_STATUS):
                    rdat_q <= {21'h0, line_cnt_q, parity_q};
                default:
                    rdat_q <= 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= '{contrast: `MVX_CONTRAST_RST, luma_filter_select: 2'h0, chroma_filter_select: 3'h0,
                bus8: 1'b1, sat_u: `MVX_SAT_RST, sat_v: `MVX_SAT_RST};
        end else if (ce_i && req && wb_we_i && ack_q) begin
            case (idx)
                10'(`MVX_IDX_CONTRAST): begin
                    if (wb_sel_i[1]) ctrl_q.contrast <= wb_dat_i[`MVX_CONTRAST_LSB +: 6];
                end
                10'(`MVX_IDX_MODE): begin
                    if (wb_sel_i[0]) ctrl_q.bus8 <= wb_dat_i[`MVX_BUS8_BIT];
                    if (wb_sel_i[1]) ctrl_q.luma_filter_select <= wb_dat_i[`MVX_LUMA_SEL_LSB +: 2];
                    if (wb_sel_i[1]) ctrl_q.chroma_filter_select <= wb_dat_i[`MVX_CHROMA_SEL_LSB +: 3];
                end
                10'(`MVX_IDX_SAT): begin
                    if (wb_sel_i[0]) ctrl_q.sat_u <= wb_dat_i[`MVX_SAT_U_LSB +: 6];
                    if (wb_sel_i[1] && wb_sel_i[0]) ctrl_q.sat_v <= wb_dat_i[`MVX_SAT_V_LSB +: 6];
                end
                default: ;
            endcase
        end
    end

    // line timing
    logic [1:0] ph_q;
    logic [2:0] cph_q;
    logic [1:0] slot_q;
    logic [9:0] wr_adr_q;
    logic [9:0] lrd_adr_q;
    logic [8:0] crd_adr_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && frame_start_i)) begin
            parity_q <= 1'b0;
            line_cnt_q <= 10'h000;
        end else if (ce_i && line_start_i) begin
            parity_q <= !parity_q;
            line_cnt_q <= line_cnt_q + 10'h001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= 2'h0;
            cph_q <= 3'h0;
        end else if (ce_i) begin
            ph_q <= (line_start_i || ph_q == `MVX_TICKS_PER_CHROMA - 2'd1) ? 2'h0 : ph_q + 2'h1;
            cph_q <= (line_start_i || cph_q == `MVX_CHROMA_CYCLE - 3'd1) ? 3'h0 : cph_q + 3'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_q <= 2'h0;
        end else if (ce_i && line_start_i) begin
            slot_q <= (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && line_start_i)) begin
            wr_adr_q <= 10'h000;
            lrd_adr_q <= 10'h000;
            crd_adr_q <= 9'h000;
        end else if (ce_i) begin
            if (luma_wr_i || chroma_wr_i) wr_adr_q <= wr_adr_q + 10'h001;
            if (ph_q != 2'h2) lrd_adr_q <= lrd_adr_q + 10'h001;
            if (ph_q == 2'h2) crd_adr_q <= crd_adr_q + 9'h001;
        end
    end

    // luma store and interpolator
    logic [7:0] luma_rd;
    logic [7:0] l_old_q;
    logic [7:0] l_new_q;
    logic [7:0] l_int_q;
    logic [7:0] luma_out;
    logic [1:0] ph_d1_q;
    mvx_line_ram #(.AW(`MVX_LUMA_AW)) u_luma_ram (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(luma_wr_i),
        .waddr_i(wr_adr_q),
        .wdata_i(sample_i),
        .raddr_i(lrd_adr_q),
        .rdata_o(luma_rd)
    );
    function automatic logic [7:0] mvx_blend(input logic [7:0] a, input logic [7:0] b, input logic [3:0] w,
            input logic sgn);
        logic [12:0] sa;
        logic [12:0] sb;
        logic [12:0] s;
        sa = sgn ? {{5{a[7]}}, a} : {5'h00, a};
        sb = sgn ? {{5{b[7]}}, b} : {5'h00, b};
        s = sa * 13'(4'd8 - w) + sb * 13'(w) + 13'h0004;
        return s[10:3];
    endfunction
    function automatic logic [3:0] mvx_luma_w(input logic [1:0] sel);
        case (sel)
            2'h0: return 4'h5;
            2'h1: return 4'h4;
            2'h2: return 4'h3;
            default: return 4'h2;
        endcase
    endfunction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_d1_q <= 2'h0;
            l_old_q <= 8'h00;
            l_new_q <= 8'h00;
            l_int_q <= 8'h00;
        end else if (ce_i) begin
            ph_d1_q <= ph_q;
            if (ph_d1_q != 2'h2) begin
                l_old_q <= l_new_q;
                l_new_q <= luma_rd;
            end
            case (ph_d1_q)
                2'h0: l_int_q <= l_new_q;
                2'h1: l_int_q <= mvx_blend(l_old_q, l_new_q, mvx_luma_w(ctrl_q.luma_filter_select), 1'b0);
                default: l_int_q <= mvx_blend(l_old_q, l_new_q, 4'd8 - mvx_luma_w(ctrl_q.luma_filter_select),
                    1'b0);
            endcase
        end
    end
    mvx_sat_mul #(.SIGNED(1'b0)) u_contrast (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_i(l_int_q),
        .k_i(ctrl_q.contrast),
        .p_o(luma_out)
    );

    // chroma store, three line slots read in turn
    logic [1:0] prev_slot;
    logic [1:0] cur_slot;
    logic [1:0] rd_slot;
    logic [7:0] chroma_rd;
    logic [7:0] c_prev_q;
    logic [7:0] c_cur_q;
    logic [7:0] u_q;
    logic [7:0] v_q;
    logic [8:0] avg;
    assign prev_slot = (slot_q == 2'h0) ? 2'h1 : (slot_q == 2'h1) ? 2'h2 : 2'h0;
    assign cur_slot = (slot_q == 2'h0) ? 2'h2 : slot_q - 2'h1;
    assign rd_slot = (ph_q == 2'h0) ? prev_slot : (ph_q == 2'h1) ? cur_slot : slot_q;
    mvx_line_ram #(.AW(`MVX_CHROMA_AW + 2)) u_chroma_ram (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(chroma_wr_i),
        .waddr_i({slot_q, wr_adr_q[8:0]}),
        .wdata_i(sample_i),
        .raddr_i({rd_slot, crd_adr_q}),
        .rdata_o(chroma_rd)
    );
    assign avg = 9'({c_prev_q[7], c_prev_q}) + 9'({chroma_rd[7], chroma_rd});
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_prev_q <= 8'h00;
            c_cur_q <= 8'h00;
            u_q <= 8'h00;
            v_q <= 8'h00;
        end else if (ce_i) begin
            if (ph_q == 2'h1) c_prev_q <= chroma_rd;
            if (ph_q == 2'h2) c_cur_q <= chroma_rd;
            if (ph_q == 2'h0) begin
                if (!parity_q) begin
                    u_q <= c_cur_q;
                    v_q <= avg[8:1];
                end else begin
                    u_q <= avg[8:1];
                    v_q <= c_cur_q;
                end
            end
        end
    end

    // chroma interpolator, 2 in for 3 out per six ticks
    logic [7:0] u_old_q;
    logic [7:0] v_old_q;
    logic [7:0] u_i_q;
    logic [7:0] v_i_q;
    logic [7:0] u_sat;
    logic [7:0] v_sat;
    logic [3:0] cw;
    assign cw = {1'b0, ctrl_q.chroma_filter_select} + 4'h1;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            u_old_q <= 8'h00;
            v_old_q <= 8'h00;
            u_i_q <= 8'h00;
            v_i_q <= 8'h00;
        end else if (ce_i) begin
            if (cph_q == 3'h1 || cph_q == 3'h4) begin
                u_old_q <= u_q;
                v_old_q <= v_q;
            end
            case (cph_q)
                3'h0: begin
                    u_i_q <= u_old_q;
                    v_i_q <= v_old_q;
                end
                3'h2: begin
                    u_i_q <= mvx_blend(u_old_q, u_q, cw, 1'b1);
                    v_i_q <= mvx_blend(v_old_q, v_q, cw, 1'b1);
                end
                3'h4: begin
                    u_i_q <= mvx_blend(u_old_q, u_q, 4'd8 - cw, 1'b1);
                    v_i_q <= mvx_blend(v_old_q, v_q, 4'd8 - cw, 1'b1);
                end
                default: ;
            endcase
        end
    end
    mvx_sat_mul #(.SIGNED(1'b1)) u_sat_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_i(u_i_q),
        .k_i(ctrl_q.sat_u),
        .p_o(u_sat)
    );
    mvx_sat_mul #(.SIGNED(1'b1)) u_sat_v (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_i(v_i_q),
        .k_i(ctrl_q.sat_v),
        .p_o(v_sat)
    );

    // colour multiplexer
    mvx_slot_t mx_q;
    logic [7:0] mx_dat_q;
    logic mx_vld_q;
    logic [7:0] luma_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mx_q <= MVX_U_HI;
            mx_dat_q <= 8'h00;
            mx_vld_q <= 1'b0;
            luma_q <= 8'h00;
        end else if (ce_i) begin
            luma_q <= luma_out;
            mx_vld_q <= 1'b1;
            case (mx_q)
                MVX_U_HI: begin
                    mx_dat_q <= ctrl_q.bus8 ? u_sat : {4'h0, u_sat[7:4]};
                    mx_q <= ctrl_q.bus8 ? MVX_V_HI : MVX_U_LO;
                end
                MVX_U_LO: begin
                    mx_dat_q <= {4'h0, u_sat[3:0]};
                    mx_q <= MVX_V_HI;
                end
                MVX_V_HI: begin
                    mx_dat_q <= ctrl_q.bus8 ? v_sat : {4'h0, v_sat[7:4]};
                    mx_q <= ctrl_q.bus8 ? MVX_U_HI : MVX_V_LO;
                end
                MVX_V_LO: begin
                    mx_dat_q <= {4'h0, v_sat[3:0]};
                    mx_q <= MVX_U_HI;
                end
                default: begin
                    mx_dat_q <= 8'h00;
                    mx_q <= MVX_U_HI;
                end
            endcase
        end
    end
    assign video_o = '{luma: luma_q, chroma: mx_dat_q, chroma_valid: mx_vld_q};
    assign chroma_bus8_o = ctrl_q.bus8;

    // checks
    sequence s_line_then_frame;
        ce_i && line_start_i && !frame_start_i;
    endsequence
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    property p_parity_toggle;
        @(posedge clk_i) disable iff (rst_i) s_line_then_frame |=> (parity_q != $past(parity_q));
    endproperty
    a_parity_toggle: assert property (p_parity_toggle) else $error("parity did not toggle");
    property p_parity_frame;
        @(posedge clk_i) disable iff (rst_i) (ce_i && frame_start_i) |=> !parity_q;
    endproperty
    a_parity_frame: assert property (p_parity_frame) else $error("parity not cleared at frame");
    property p_luma_rate;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && ph_q == 2'h2 && !line_start_i) |=> (lrd_adr_q == $past(lrd_adr_q));
    endproperty
    a_luma_rate: assert property (p_luma_rate) else $error("luma read on third tick");
    property p_even_u;
        @(posedge clk_i) disable iff (rst_i) (ce_i && ph_q == 2'h0 && !parity_q) |=> (u_q == $past(c_cur_q));
    endproperty
    a_even_u: assert property (p_even_u) else $error("even line u not passed");
    property p_odd_v;
        @(posedge clk_i) disable iff (rst_i) (ce_i && ph_q == 2'h0 && parity_q) |=> (v_q == $past(c_cur_q));
    endproperty
    a_odd_v: assert property (p_odd_v) else $error("odd line v not passed");
    property p_nibble;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !ctrl_q.bus8) |=> (mx_dat_q[7:4] == 4'h0);
    endproperty
    a_nibble: assert property (p_nibble) else $error("4-line bus used upper lines");
    property p_mode_write;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && req && wb_we_i && ack_q && idx == 10'(`MVX_IDX_MODE) && wb_sel_i[0])
        |=> (ctrl_q.bus8 == $past(wb_dat_i[`MVX_BUS8_BIT]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("bus format bit not written");
endmodule
`default_nettype wire

// File: mvx_codec_model.sv
// codec-side model collecting luma and colour bus words
`default_nettype none
module mvx_codec_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    // video from the path
    input wire mvx_pkg::mvx_video_t video_i,
    input wire logic bus8_i,
    // collected words
    output logic [255:0] luma_seen_o,
    output logic [255:0] chroma_seen_o,
    output logic [31:0] hist_o
);
    import mvx_pkg::*;
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            luma_seen_o <= '0;
            chroma_seen_o <= '0;
            hist_o <= '0;
        end else begin
            luma_seen_o[video_i.luma] <= 1'b1;
            if (video_i.chroma_valid) begin
                chroma_seen_o[video_i.chroma] <= 1'b1;
                if (bus8_i) begin
                    hist_o <= {hist_o[23:0], video_i.chroma};
                end else begin
                    hist_o <= {hist_o[27:0], video_i.chroma[3:0]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: mvx_video_path_bench.sv
// self-checking bench of the video expansion path
`default_nettype none
`include "mvx_params.svh"
module mvx_video_path_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mvx_pkg::*;
    localparam int LINE = 128;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ls = 1'b0, fs = 1'b0, clr = 1'b0, ce = 1'b1;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, hist;
    logic [7:0] smp = 8'h00;
    logic ack, bus8;
    mvx_video_t vid;
    logic [255:0] lseen, cseen;
    int miscompares = 0, cmp_count = 0;
    always #5 clk = ~clk;
    mvx_video_path u_mvx_video_path (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sample_i(smp), .line_start_i(ls), .frame_start_i(fs), .luma_wr_i(1'b1), .chroma_wr_i(1'b1),
        .video_o(vid), .chroma_bus8_o(bus8));
    mvx_codec_model u_mvx_codec_model (.clk_i(clk), .rst_i(rst), .clr_i(clr), .video_i(vid), .bus8_i(bus8),
        .luma_seen_o(lseen), .chroma_seen_o(cseen), .hist_o(hist));
    task automatic check(input logic [255:0] s, input logic [255:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, 4'h3, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        wb(1'b0, idx, 4'h3, 32'h0, q);
    endtask
    function automatic logic [31:0] mode(input logic [2:0] cs, input logic [1:0] lsel, input logic b8);
        return (32'(cs) << `MVX_CHROMA_SEL_LSB) | (32'(lsel) << `MVX_LUMA_SEL_LSB) | (32'(b8) << `MVX_BUS8_BIT);
    endfunction
    function automatic logic [31:0] sat(input logic [5:0] u, input logic [5:0] v);
        return (32'(v) << `MVX_SAT_V_LSB) | (32'(u) << `MVX_SAT_U_LSB);
    endfunction
    function automatic logic [255:0] one(input logic [7:0] a);
        return 256'h1 << a;
    endfunction
    function automatic logic rot_ok(input logic [15:0] h, input logic [15:0] r);
        logic [31:0] rr;
        rr = {r, r};
        for (int k = 0; k < 4; k++) begin
            if (h === rr[31-4*k -: 16]) return 1'b1;
        end
        return 1'b0;
    endfunction
    task automatic line(input logic [7:0] v);
        for (int i = 0; i < LINE; i++) begin
            @(posedge clk);
            ls <= (i == 0);
            smp <= v;
        end
    endtask
    task automatic clear_seen;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic measure(input logic [7:0] v);
        repeat (3) line(v);
        clear_seen();
        repeat (2) line(v);
    endtask
    task automatic line_alt;
        for (int i = 0; i < LINE; i++) begin
            @(posedge clk);
            ls <= (i == 0);
            smp <= (i % 2 == 0) ? 8'h00 : 8'h80;
        end
    endtask
    task automatic t_shape;
        logic [255:0] pl, pc;
        pl = '0;
        pc = '0;
        wr(`MVX_IDX_SAT, sat(6'h20, 6'h20));
        wr(`MVX_IDX_CONTRAST, 32'h20 << `MVX_CONTRAST_LSB);
        for (int i = 0; i < 8; i++) begin
            wr(`MVX_IDX_MODE, mode(3'(i), 2'(i), 1'b1));
            repeat (3) line_alt();
            clear_seen();
            repeat (2) line_alt();
            check(lseen != pl, 1'b1);
            check(cseen != pc, 1'b1);
            pl = lseen;
            pc = cseen;
        end
        $display("test shape done");
    endtask
    task automatic t_freeze;
        mvx_video_t v0;
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        v0 = vid;
        repeat (8) @(posedge clk);
        check(vid, v0);
        ce <= 1'b1;
        $display("test freeze done");
    endtask
    task automatic t_regs;
        logic [31:0] q, q2;
        rd(`MVX_IDX_SAT, q);
        check(q, 32'h820);
        rd(`MVX_IDX_CONTRAST, q);
        check(q, 32'h8000);
        rd(`MVX_IDX_MODE, q);
        check(q, 32'h40);
        wb(1'b1, `MVX_IDX_SAT, 4'h1, 32'hffff, q);
        rd(`MVX_IDX_SAT, q);
        check(q, 32'h83f);
        wr(8'h01, 32'hffff);
        rd(8'h01, q);
        check(q, 32'h0);
        rd(`MVX_IDX_STATUS, q);
        wr(`MVX_IDX_STATUS, 32'hffff);
        rd(`MVX_IDX_STATUS, q2);
        check(q2, q);
        wr(`MVX_IDX_MODE, mode(3'h7, 2'h3, 1'b0));
        rd(`MVX_IDX_MODE, q);
        check(q, 32'hec00);
        $display("test regs done");
    endtask
    task automatic t_filters;
        wr(`MVX_IDX_SAT, sat(6'h20, 6'h20));
        wr(`MVX_IDX_CONTRAST, 32'h20 << `MVX_CONTRAST_LSB);
        for (int i = 0; i < 8; i++) begin
            wr(`MVX_IDX_MODE, mode(3'(i), 2'(i), 1'b1));
            measure(8'h40);
            check(lseen, one(8'h40));
            check(cseen, one(8'h40));
        end
        $display("test filters done");
    endtask
    task automatic t_gain;
        wr(`MVX_IDX_SAT, sat(6'h2d, 6'h3f));
        wr(`MVX_IDX_CONTRAST, 32'h3f << `MVX_CONTRAST_LSB);
        wr(`MVX_IDX_MODE, mode(3'h0, 2'h0, 1'b1));
        measure(8'h40);
        check(lseen, one(8'h7e));
        check(cseen, one(8'h5a) | one(8'h7e));
        check(rot_ok(hist[15:0], 16'h5a7e), 1'b1);
        measure(8'h60);
        check(lseen, one(8'hbd));
        check(cseen, one(8'h7f));
        measure(8'ha0);
        check(lseen, one(8'hff));
        check(cseen, one(8'h80));
        wr(`MVX_IDX_MODE, mode(3'h0, 2'h0, 1'b0));
        measure(8'h40);
        check(bus8, 1'b0);
        check(cseen, one(8'h05) | one(8'h0a) | one(8'h07) | one(8'h0e));
        check(rot_ok(hist[15:0], 16'h5a7e), 1'b1);
        $display("test gain done");
    endtask
    task automatic t_interp;
        wr(`MVX_IDX_SAT, sat(6'h20, 6'h20));
        wr(`MVX_IDX_CONTRAST, 32'h20 << `MVX_CONTRAST_LSB);
        wr(`MVX_IDX_MODE, mode(3'h0, 2'h0, 1'b1));
        repeat (3) line(8'h00);
        clear_seen();
        for (int k = 0; k < 6; k++) line((k % 3 == 0) ? 8'h40 : 8'h00);
        check(bus8, 1'b1);
        check(cseen[8'h20], 1'b1);
        check(cseen[8'h40], 1'b1);
        $display("test interp done");
    endtask
    task automatic t_parity;
        logic [31:0] q, q2;
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        rd(`MVX_IDX_STATUS, q);
        check(q[0], 1'b0);
        line(8'h00);
        rd(`MVX_IDX_STATUS, q2);
        check(q2[0], 1'b1);
        check(q2[10:1] - q[10:1], 10'h001);
        line(8'h00);
        rd(`MVX_IDX_STATUS, q);
        check(q[0], 1'b0);
        $display("test parity done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        check(vid, '0);
        check(bus8, 1'b1);
        rst <= 1'b0;
        t_regs();
        t_filters();
        t_shape();
        t_gain();
        t_freeze();
        t_interp();
        t_parity();
        print_verdict();
    end
    initial begin
        #600000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
